//--- inc/efq_pkg.sv
// constants for the external flash port and its query qualifier
// assumes a 100 MHz system clock and a 16-bit word-wide part
package efq_pkg;
   localparam int unsigned ADDR_W = 21;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // write strobe low time, least, rounded up
   localparam int unsigned WE_LOW_NS = 100;
   localparam int unsigned WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // read strobe length, covers the 110 ns access time
   localparam int unsigned RD_ACC_NS = 110;
   localparam int unsigned RD_CYC = (RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // delay of the flash reset behind the hard reset
   localparam int unsigned MRST_DLY_CYC = 3;
   // query structure word offsets
   localparam logic [20:0] Q_PRI_CODE = 21'h000013;
   localparam logic [20:0] Q_ALT_CODE = 21'h000017;
   localparam logic [20:0] Q_REGION_CNT = 21'h00002C;
   localparam logic [20:0] Q_REGION_BASE = 21'h00002D;
   // accepted command-set codes
   localparam logic [15:0] CS_EXT_A = 16'h0001;
   localparam logic [15:0] CS_STD_B = 16'h0002;
   localparam logic [15:0] CS_STD_A = 16'h0003;
   localparam logic [15:0] CS_EXT_B = 16'h0701;
   // region word: count-1 in [15:0], size/256 in [31:16]
   localparam logic [15:0] SZ_2K = 16'h0008;
   localparam logic [15:0] SZ_4K = 16'h0010;
   localparam logic [15:0] SZ_8K = 16'h0020;
   localparam logic [15:0] SZ_16K = 16'h0040;
   localparam logic [15:0] SZ_32K = 16'h0080;
   localparam logic [15:0] SZ_64K = 16'h0100;
endpackage : efq_pkg

//--- rtl/efq_strobe_cnt.sv
// down counter that times one strobe of the memory port
// assumes load and load_val come from the sequencer in the same clock
`timescale 1ns/10ps
module efq_strobe_cnt #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   // status
   output logic done
);
   logic [W-1:0] cnt_q; // cycles still to run
   // count down to zero after a load
   always_ff @(posedge clock) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= load_val;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
   assign done = (cnt_q == '0) && !load;
endmodule : efq_strobe_cnt

//--- rtl/efq_flash_port.sv
// external parallel flash port with strobe sequencer and query qualifier
// assumes a word-wide flash in query mode when the qualify walk runs
// How it works
// - sixteen data lines, twenty-one address lines
// - write strobe low only while writing
// - read strobe low only while reading
// - select low for every transfer only
// - flash reset trails every hard reset
// - accept four command-set codes only
// - read erase regions from offset 0x2d
// - accept uniform 4KB or 2KB layouts
// - accept four-region or 8KB+64KB layouts
// - adapt only when query data qualifies
// - processor fetches code through this port
`timescale 1ns/10ps
module efq_flash_port #(
   parameter int unsigned CNT_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // user access request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [20:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata,
   // qualify control and result
   input wire logic qual_start,
   output logic qual_busy,
   output logic qual_done,
   output logic qual_ok,
   output logic [15:0] qual_cmd_set,
   // memory pins
   output logic [20:0] mem_addr,
   input wire logic [15:0] mem_data_in,
   output logic [15:0] mem_data_out,
   output logic mem_data_oe,
   output logic mem_we_n,
   output logic mem_oe_n,
   output logic mem_cs_n,
   output logic memory_reset_n
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10,
      ST_HOLD = 2'b11
   } efq_st_t;
   efq_st_t st_q; // port sequencer state
   logic [20:0] addr_q; // latched address
   logic [15:0] wdat_q; // latched write data
   logic own_q; // access belongs to the qualifier
   logic cnt_load; // start strobe timer
   logic [CNT_W-1:0] cnt_val; // strobe length
   logic cnt_done; // strobe timer expired
   logic [efq_pkg::MRST_DLY_CYC-1:0] rst_sh_q; // reset delay chain
   // qualifier walk
   logic [3:0] qstep_q; // index of query word
   logic [15:0] qbuf_q [0:10]; // captured query words
   logic qreq; // qualifier wants a read
   logic [20:0] qaddr; // qualifier read address
   logic take; // new access accepted
   logic fin; // strobe ending this cycle
   logic last_q; // last query word landed at the previous edge
   logic [CNT_W-1:0] we_run_q; // write strobe low cycles so far

   // flash reset delay
   // shift ones in after reset; nothing else moves it
   always_ff @(posedge clock) begin
      if (reset) begin
         rst_sh_q <= '0;
      end else begin
         rst_sh_q <= {rst_sh_q[efq_pkg::MRST_DLY_CYC-2:0], 1'b1};
      end
   end
   assign memory_reset_n = rst_sh_q[efq_pkg::MRST_DLY_CYC-1];

   // qualifier reads go first; the user waits meanwhile
   assign qreq = qual_busy && (st_q == ST_IDLE);
   assign qaddr = (qstep_q == 4'h0) ? efq_pkg::Q_PRI_CODE :
                  (qstep_q == 4'h1) ? efq_pkg::Q_ALT_CODE :
                  (qstep_q == 4'h2) ? efq_pkg::Q_REGION_CNT :
                  21'(efq_pkg::Q_REGION_BASE + 21'(qstep_q) - 21'h3);
   assign req_ready = (st_q == ST_IDLE) && !qual_busy && memory_reset_n;
   assign take = qreq || (req_valid && req_ready);
   assign fin = cnt_done && ((st_q == ST_READ) || (st_q == ST_WRITE));
   assign cnt_load = take;
   assign cnt_val = (!qreq && req_write) ? CNT_W'(efq_pkg::WE_LOW_CYC - 1) : CNT_W'(efq_pkg::RD_CYC - 1);

   efq_strobe_cnt #(.W(CNT_W)) u_cnt (
      .clock(clock),
      .reset(reset),
      .load(cnt_load),
      .load_val(cnt_val),
      .done(cnt_done)
   );

   // sequencer: idle, strobe, one hold cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (take) begin
                  st_q <= (!qreq && req_write) ? ST_WRITE : ST_READ;
               end
            end
            ST_READ, ST_WRITE: begin
               if (fin) begin
                  st_q <= ST_HOLD;
               end
            end
            ST_HOLD: st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // address and data latched at take
   always_ff @(posedge clock) begin
      if (reset) begin
         addr_q <= '0;
         wdat_q <= '0;
         own_q <= 1'b0;
      end else if (take) begin
         addr_q <= qreq ? qaddr : req_addr;
         wdat_q <= req_wdata;
         own_q <= qreq;
      end
   end
   assign mem_addr = addr_q;
   assign mem_data_out = wdat_q;
   assign mem_data_oe = (st_q == ST_WRITE);
   assign mem_we_n = !(st_q == ST_WRITE);
   assign mem_oe_n = !(st_q == ST_READ);
   // select per transfer, covers the hold cycle
   assign mem_cs_n = (st_q == ST_IDLE);

   // read data back to the fetch side
   always_ff @(posedge clock) begin
      if (reset) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= fin && (st_q == ST_READ) && !own_q;
         if (fin && (st_q == ST_READ)) begin
            rsp_rdata <= mem_data_in;
         end
      end
   end

   // walk: codes, region count, region words
   always_ff @(posedge clock) begin
      if (reset) begin
         qual_busy <= 1'b0;
         qstep_q <= '0;
         for (int i = 0; i < 11; i++) begin
            qbuf_q[i] <= '0;
         end
      end else if (qual_start && !qual_busy && (st_q == ST_IDLE)) begin
         qual_busy <= 1'b1;
         qstep_q <= '0;
      end else if (fin && own_q) begin
         qbuf_q[qstep_q] <= mem_data_in;
         if (qstep_q == 4'hA) begin
            qual_busy <= 1'b0;
         end
         qstep_q <= qstep_q + 4'h1;
      end
   end

   // verdict on the captured words
   function automatic logic cs_ok(input logic [15:0] c);
      return (c == efq_pkg::CS_EXT_A) || (c == efq_pkg::CS_STD_B) ||
             (c == efq_pkg::CS_STD_A) || (c == efq_pkg::CS_EXT_B);
   endfunction
   function automatic logic rg(input logic [15:0] lo, input logic [15:0] hi,
                               input logic [15:0] sz, input logic [15:0] n);
      return (hi == sz) && (lo == 16'(n - 16'h1));
   endfunction
   function automatic logic n64(input logic [15:0] lo, input logic [15:0] hi);
      return rg(lo, hi, efq_pkg::SZ_64K, 16'h0007) || rg(lo, hi, efq_pkg::SZ_64K, 16'h000F) ||
             rg(lo, hi, efq_pkg::SZ_64K, 16'h001F) || rg(lo, hi, efq_pkg::SZ_64K, 16'h003F);
   endfunction
   logic code_ok; // a known command set
   logic lay_ok; // a known erase layout
   logic [15:0] r_n; // region count
   always_comb begin
      r_n = qbuf_q[2];
      code_ok = cs_ok(qbuf_q[0]) || cs_ok(qbuf_q[1]);
      lay_ok = 1'b0;
      if (r_n == 16'h0001) begin
         lay_ok = rg(qbuf_q[3], qbuf_q[4], efq_pkg::SZ_4K, 16'h0080) ||
                  rg(qbuf_q[3], qbuf_q[4], efq_pkg::SZ_4K, 16'h0100) ||
                  rg(qbuf_q[3], qbuf_q[4], efq_pkg::SZ_4K, 16'h0200) ||
                  rg(qbuf_q[3], qbuf_q[4], efq_pkg::SZ_4K, 16'h0400) ||
                  rg(qbuf_q[3], qbuf_q[4], efq_pkg::SZ_2K, 16'h0100) ||
                  rg(qbuf_q[3], qbuf_q[4], efq_pkg::SZ_2K, 16'h0200) ||
                  rg(qbuf_q[3], qbuf_q[4], efq_pkg::SZ_2K, 16'h0400) ||
                  rg(qbuf_q[3], qbuf_q[4], efq_pkg::SZ_2K, 16'h0800);
      end else if (r_n == 16'h0002) begin
         lay_ok = (qbuf_q[4] == efq_pkg::SZ_8K) && n64(qbuf_q[5], qbuf_q[6]);
      end else if (r_n == 16'h0004) begin
         lay_ok = rg(qbuf_q[3], qbuf_q[4], efq_pkg::SZ_16K, 16'h0001) &&
                  rg(qbuf_q[5], qbuf_q[6], efq_pkg::SZ_8K, 16'h0002) &&
                  rg(qbuf_q[7], qbuf_q[8], efq_pkg::SZ_32K, 16'h0001) &&
                  n64(qbuf_q[9], qbuf_q[10]);
      end
   end

   // verdict waits one edge so no half-read layout is ever reported
   always_ff @(posedge clock) begin
      last_q <= !reset && fin && own_q && (qstep_q == 4'hA);
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         qual_done <= 1'b0;
         qual_ok <= 1'b0;
         qual_cmd_set <= '0;
      end else if (qual_start && !qual_busy && (st_q == ST_IDLE)) begin
         qual_done <= 1'b0;
         qual_ok <= 1'b0;
      end else if (last_q) begin
         qual_done <= 1'b1;
         qual_ok <= code_ok && lay_ok;
         qual_cmd_set <= cs_ok(qbuf_q[0]) ? qbuf_q[0] : qbuf_q[1];
      end
   end

   property p_no_both;
      @(posedge clock) disable iff (reset) !(!mem_we_n && !mem_oe_n);
   endproperty
   a_no_both: assert property (p_no_both) else $error("both strobes low");
   property p_bus_rel;
      @(posedge clock) disable iff (reset) mem_data_oe |-> !mem_we_n;
   endproperty
   a_bus_rel: assert property (p_bus_rel) else $error("data driven outside write");
   property p_cs;
      @(posedge clock) disable iff (reset) (!mem_we_n || !mem_oe_n) |-> !mem_cs_n;
   endproperty
   a_cs: assert property (p_cs) else $error("strobe without select");
   // low-time counter for the width check
   always_ff @(posedge clock) begin
      if (reset || mem_we_n) begin
         we_run_q <= '0;
      end else if (we_run_q != '1) begin
         we_run_q <= we_run_q + 1'b1;
      end
   end
   property p_we_len;
      @(posedge clock) disable iff (reset) $rose(mem_we_n) |-> (we_run_q >= CNT_W'(efq_pkg::WE_LOW_CYC));
   endproperty
   a_we_len: assert property (p_we_len) else $error("write strobe short");
   property p_addr;
      @(posedge clock) disable iff (reset) (!mem_cs_n && $past(!mem_cs_n)) |-> $stable(mem_addr);
   endproperty
   a_addr: assert property (p_addr) else $error("address moved in access");
   property p_mrst;
      @(posedge clock) $fell(reset) |-> !memory_reset_n [*3] ##1 memory_reset_n;
   endproperty
   a_mrst: assert property (p_mrst) else $error("flash reset delay wrong");
   property p_rd;
      @(posedge clock) disable iff (reset) $rose(mem_oe_n) && !own_q |-> rsp_valid;
   endproperty
   a_rd: assert property (p_rd) else $error("read without response");
   property p_ok;
      @(posedge clock) disable iff (reset) qual_ok |-> qual_done && !qual_busy;
   endproperty
   a_ok: assert property (p_ok) else $error("qualified early");
endmodule : efq_flash_port

//--- sim/efq_flash_model.sv
// behavioural word-wide flash that answers reads and programs words
// assumes the bench resolves the shared data lines from the port data enable alone
`timescale 1ns/10ps
module efq_flash_model (
   // memory pins
   input wire logic [20:0] mem_addr,
   input wire logic [15:0] bus,
   input wire logic mem_we_n,
   input wire logic mem_oe_n,
   input wire logic mem_cs_n,
   // level the part drives
   output logic [15:0] drv
);
   logic [15:0] mem [0:63];
   logic [15:0] last = 16'hA5A5; // last word driven
   logic [15:0] wd = 16'h0000; // captured write word
   realtime t_fall = 0.0; // write strobe fall time
   initial begin
      for (int i = 0; i < 64; i++) mem[i] = 16'hFFFF;
   end
   // full word out, inverse of last once released
   always_comb begin
      drv = (!mem_cs_n && !mem_oe_n) ? mem[mem_addr[5:0]] : ~last;
   end
   always @(posedge mem_oe_n) last = mem[mem_addr[5:0]];
   // mid-strobe capture avoids the edge race with the enable
   always @(negedge mem_we_n) begin
      t_fall = $realtime;
      #50 wd = bus;
   end
   // long enough strobe, bits only clear
   always @(posedge mem_we_n) begin
      if (!mem_cs_n && ($realtime - t_fall >= 100.0)) mem[mem_addr[5:0]] = mem[mem_addr[5:0]] & wd;
   end
endmodule : efq_flash_model

//--- sim/test_external_flash_port_cfi_qualify.sv
// bench for the flash port: reset, word access, query qualify walks
// assumes the flash model on the pins and the package constants
`timescale 1ns/10ps
module test_external_flash_port_cfi_qualify;
   // stimulus
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [20:0] req_addr = 21'h000000;
   logic [15:0] req_wdata = 16'h0000;
   logic qual_start = 1'b0;
   // design outputs
   logic req_ready, rsp_valid, qual_busy, qual_done, qual_ok;
   logic [15:0] rsp_rdata, qual_cmd_set, mem_data_out, drv;
   logic [20:0] mem_addr;
   logic mem_data_oe, mem_we_n, mem_oe_n, mem_cs_n, memory_reset_n;
   wire logic [15:0] bus = mem_data_oe ? mem_data_out : drv; // resolved lines
   int errors = 0;
   int n_tests = 0;
   int we_cnt = 0; // write strobe low cycles
   logic cs_low = 1'b0;
   logic [20:0] a_prev = 21'h000000;
   efq_flash_port dut (.clock(clock), .reset(reset), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .qual_start(qual_start), .qual_busy(qual_busy), .qual_done(qual_done),
      .qual_ok(qual_ok), .qual_cmd_set(qual_cmd_set), .mem_addr(mem_addr), .mem_data_in(bus),
      .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_we_n(mem_we_n),
      .mem_oe_n(mem_oe_n), .mem_cs_n(mem_cs_n), .memory_reset_n(memory_reset_n));
   efq_flash_model flash (.mem_addr(mem_addr), .bus(bus), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
      .mem_cs_n(mem_cs_n), .drv(drv));
   initial begin
      forever #5 clock = ~clock;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // pin relations watched every settled cycle
   always @(negedge clock) begin
      if (!reset) begin
         check("pins", {~(mem_we_n | mem_oe_n), mem_cs_n & ~(mem_we_n & mem_oe_n), mem_data_oe ^ ~mem_we_n}, 3'h0);
         if (!mem_cs_n && cs_low) check("addr", mem_addr, a_prev);
         cs_low = !mem_cs_n;
         a_prev = mem_addr;
         if (!mem_we_n) we_cnt++;
      end
   end
   task automatic do_reset();
      int n;
      @(posedge clock);
      reset <= 1'b1;
      repeat (4) @(posedge clock);
      check("rst_low", memory_reset_n, 1'b0);
      reset <= 1'b0;
      n = 0;
      do begin @(negedge clock); n++; end while (memory_reset_n !== 1'b1 && n < 20);
      check("rst_dly", n, efq_pkg::MRST_DLY_CYC + 1);
   endtask : do_reset
   // one word access; n counts cycles to the answer
   task automatic access(input logic w, input logic [20:0] a, input logic [15:0] d, output logic [15:0] q,
         output int n);
      @(posedge clock);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      do @(posedge clock); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      n = 0;
      do begin @(negedge clock); n++; end while (n < 20 && (w ? req_ready : rsp_valid) !== 1'b1);
      q = rsp_rdata;
   endtask : access
   task automatic data_test();
      logic [15:0] q;
      int n;
      we_cnt = 0;
      access(1'b1, 21'h00003A, 16'hF0F0, q, n);
      check("we_len", we_cnt, efq_pkg::WE_LOW_CYC);
      check("wr_lat", n, efq_pkg::WE_LOW_CYC + 2);
      access(1'b1, 21'h00003A, 16'h3CFF, q, n);
      access(1'b0, 21'h00003A, 16'h0000, q, n);
      check("rd_data", q, 16'h30F0);
      check("rd_lat", n, 12);
   endtask : data_test
   // loads the query words, runs a walk, judges the verdict
   task automatic qualify(input logic [15:0] p, input logic [15:0] alt, input logic [15:0] nr,
         input logic [127:0] r, input logic ok, input logic [15:0] cs);
      int w;
      flash.mem[6'h13] = p;
      flash.mem[6'h17] = alt;
      flash.mem[6'h2C] = nr;
      for (int i = 0; i < 8; i++) flash.mem[6'h2D + i] = r[127 - 16 * i -: 16];
      @(posedge clock);
      qual_start <= 1'b1;
      @(posedge clock);
      qual_start <= 1'b0;
      @(negedge clock);
      check("busy", {qual_busy, req_ready}, 2'h2);
      w = 0;
      do begin @(negedge clock); w++; end while (qual_done !== 1'b1 && w < 400);
      check("walk_end", qual_done, 1'b1);
      @(negedge clock);
      check("qual_ok", qual_ok, ok);
      if (ok) check("cmd_set", qual_cmd_set, cs);
   endtask : qualify
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   initial begin
      #300000;
      errors++;
      final_report();
   end
   initial begin
      logic [15:0] cs [4];
      cs = '{efq_pkg::CS_EXT_A, efq_pkg::CS_STD_B, efq_pkg::CS_STD_A, efq_pkg::CS_EXT_B};
      do_reset();
      data_test();
      // every code, every 4KB and 2KB count
      for (int i = 0; i < 4; i++) begin
         qualify(cs[i], 16'h0000, 16'h1, {16'((128 << i) - 1), efq_pkg::SZ_4K, 96'h0}, 1'b1, cs[i]);
         qualify(cs[i], 16'h0000, 16'h1, {16'((256 << i) - 1), efq_pkg::SZ_2K, 96'h0}, 1'b1, cs[i]);
         qualify(cs[i], 16'h0004, 16'h4, {16'h0, efq_pkg::SZ_16K, 16'h1, efq_pkg::SZ_8K, 16'h0, efq_pkg::SZ_32K,
            16'((8 << i) - 2), efq_pkg::SZ_64K}, 1'b1, cs[i]);
      end
      qualify(16'h0004, 16'h0005, 16'h1, {16'h7F, efq_pkg::SZ_4K, 96'h0}, 1'b0, 16'h0);
      qualify(16'h0004, efq_pkg::CS_EXT_B, 16'h1, {16'h7F, efq_pkg::SZ_4K, 96'h0}, 1'b1, efq_pkg::CS_EXT_B);
      qualify(efq_pkg::CS_STD_B, 16'h0, 16'h2, {16'h7, efq_pkg::SZ_8K, 16'h3E, efq_pkg::SZ_64K, 64'h0}, 1'b1,
         efq_pkg::CS_STD_B);
      qualify(efq_pkg::CS_STD_B, 16'h0, 16'h1, {16'h63, efq_pkg::SZ_4K, 96'h0}, 1'b0, 16'h0);
      qualify(efq_pkg::CS_STD_B, 16'h0, 16'h4, {16'h0, efq_pkg::SZ_16K, 16'h1, efq_pkg::SZ_8K, 16'h0,
         efq_pkg::SZ_32K, 16'hF, efq_pkg::SZ_64K}, 1'b0, 16'h0);
      do_reset();
      data_test();
      final_report();
   end
endmodule : test_external_flash_port_cfi_qualify
